// ==== hw/cdm_pkg.sv ====
// constants and types shared by the configuration data pin mux
package cdm_pkg;

  // configuration modes as seen by the pin mux
  typedef enum logic [3:0] {
    CDM_MODE_INIT,
    CDM_MODE_JTAG,
    CDM_MODE_SPI_X1,
    CDM_MODE_SPI_X2,
    CDM_MODE_SPI_X4,
    CDM_MODE_SPI_X8,
    CDM_MODE_SLAVE_SERIAL,
    CDM_MODE_SLAVE_PARALLEL,
    CDM_MODE_USER
  } cdm_mode_e;

  // slave parallel bus width selection
  typedef enum logic [1:0] {
    CDM_WIDTH_X8,
    CDM_WIDTH_X16,
    CDM_WIDTH_X32
  } cdm_width_e;

  localparam int CDM_BUS_W = 32;
  localparam int CDM_MID_LO = 8;
  localparam int CDM_HIGH_LO = 16;
  localparam logic [31:0] CDM_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] CDM_OE_RST = 32'h0000_0000;
  localparam logic [1:0] CDM_SYNC_RST = 2'h0;
  localparam int CDM_SPI_W = 8;
  localparam int CDM_QUAD_LO = 2;
  localparam int CDM_SECOND_LO = 4;
  localparam int CDM_DI_BIT = 1;
  localparam logic [7:0] CDM_SPI_RST = 8'h00;

endpackage

// ==== hw/cdm_sync.sv ====
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module cdm_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== hw/cdm_pin_mux.sv ====
// configuration data and control pin multiplexer
// Notes on behaviour
// - parallel mode: rw_select high means device drives data, low means accepts.
// - bus bits 31:16 used only at 32-bit parallel width.
// - bus bits 15:8 used at 16 or 32-bit parallel width.
// - data pins beyond configured width stay user I/O, undriven.
// - spi x8: pins 7:4 carry the second flash's four data lines.
// - spi x4/x8: pins 2 and 3 take flash data bits two and three.
// - spi x1: shared serial input pin is the single data input.
// - spi x2/x4/x8: shared serial input pin is data line one.
// - parallel mode: shared pins act as bus bits 1, 3:2 and 7:4.
// - slave serial: shared data-1 pin is the serial data input.
// - after configuration all muxed pins return to user I/O.
// - during init or unused mode a pin is undriven user I/O.
// - in modes like jtag the serial input pin level is ignored.
// - low chip select enables the slave parallel interface.
// - parallel bit 0 rides the serial output data-0 pin.
`timescale 1ns/1ps
`default_nettype none
module cdm_pin_mux
  import cdm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire cdm_mode_e cfg_mode,
  input wire cdm_width_e par_width,
  // data pins: bit 0 is serial_out_data0_pin, bit 1 serial_in_data1_pin
  input wire logic [31:0] data_pin_in,
  output var logic [31:0] data_pin_out,
  output var logic [31:0] data_pin_oe,
  input wire logic chip_select_n_pin,
  input wire logic rw_select,
  // configuration logic side
  input wire logic [31:0] cfg_read_data,
  output var logic [31:0] cfg_write_data,
  output var logic cfg_write_valid,
  output var logic [7:0] spi_data_in,
  output var logic spi_x1_data_in,
  output var logic serial_data_in,
  output var logic par_selected,
  output var logic par_read,
  // user logic side
  input wire logic [31:0] user_out,
  input wire logic [31:0] user_oe,
  output var logic [31:0] user_in,
  output var logic user_pins_owned
);

  // pin to output latency is three edges:
  // two sync flops, then the output register
  // mode and read data are same-domain, one edge
  logic [CDM_BUS_W-1:0] data_sync;
  logic [1:0] ctl_sync;
  wire cs_s;
  wire rw_s;

  // data pins arrive from outside the clock domain
  cdm_sync #(
    .W(CDM_BUS_W)
  ) cdm_sync_data_inst (
    .clock(clock),
    .resetn(resetn),
    .async_in(data_pin_in),
    .sync_out(data_sync)
  );

  // select synced active high: reset reads as deselected
  // so no false select follows the release of reset
  cdm_sync #(
    .W(2)
  ) cdm_sync_ctl_inst (
    .clock(clock),
    .resetn(resetn),
    .async_in({~chip_select_n_pin, rw_select}),
    .sync_out(ctl_sync)
  );

  assign cs_s = ctl_sync[1];
  assign rw_s = ctl_sync[0];

  // mode decode
  wire is_par;
  wire is_x1;
  wire is_x2;
  wire is_x4;
  wire is_x8;
  wire is_ser;
  wire is_user;
  wire spi_wide;
  wire spi_quad;
  assign is_par = (cfg_mode == CDM_MODE_SLAVE_PARALLEL);
  assign is_x1 = (cfg_mode == CDM_MODE_SPI_X1);
  assign is_x2 = (cfg_mode == CDM_MODE_SPI_X2);
  assign is_x4 = (cfg_mode == CDM_MODE_SPI_X4);
  assign is_x8 = (cfg_mode == CDM_MODE_SPI_X8);
  assign is_ser = (cfg_mode == CDM_MODE_SLAVE_SERIAL);
  assign is_user = (cfg_mode == CDM_MODE_USER);
  // modes with a second data line
  assign spi_wide = is_x2 | is_x4 | is_x8;
  assign spi_quad = is_x4 | is_x8;

  wire par_sel;
  wire par_rd;
  wire par_wr;
  assign par_sel = is_par & cs_s;
  assign par_rd = par_sel & rw_s;
  assign par_wr = par_sel & ~rw_s;

  // per-bit ownership of the pins by the parallel bus
  wire [CDM_BUS_W-1:0] par_lane;
  wire use_high;
  wire use_mid;
  assign use_high = (par_width == CDM_WIDTH_X32);
  assign use_mid = use_high | (par_width == CDM_WIDTH_X16);

  // lanes outside the width stay user I/O
  genvar gi;
  generate
    for (gi = 0; gi < CDM_BUS_W; gi++) begin : g_lane
      if (gi >= CDM_HIGH_LO) begin : g_hi
        assign par_lane[gi] = is_par & use_high;
      end else if (gi >= CDM_MID_LO) begin : g_mid
        assign par_lane[gi] = is_par & use_mid;
      end else begin : g_lo
        // bit 0 on serial output pin
        assign par_lane[gi] = is_par;
      end
    end
  endgenerate

  // spi input lanes per mode
  wire [CDM_SPI_W-1:0] spi_lane;
  generate
    for (gi = 0; gi < CDM_SPI_W; gi++) begin : g_spi
      if (gi >= CDM_SECOND_LO) begin : g_second
        assign spi_lane[gi] = is_x8;
      end else if (gi >= CDM_QUAD_LO) begin : g_quad
        assign spi_lane[gi] = spi_quad;
      end else begin : g_dual
        assign spi_lane[gi] = spi_wide;
      end
    end
  endgenerate

  // masked lanes read as zero so idle pins never leak in
  wire [CDM_SPI_W-1:0] spi_in_next;
  wire x1_in_next;
  wire ser_in_next;
  assign spi_in_next = data_sync[CDM_SPI_W-1:0] & spi_lane;
  assign x1_in_next = is_x1 & data_sync[CDM_DI_BIT];
  assign ser_in_next = is_ser & data_sync[CDM_DI_BIT];

  // per-pin drive and capture
  wire [CDM_BUS_W-1:0] oe_next;
  wire [CDM_BUS_W-1:0] out_next;
  wire [CDM_BUS_W-1:0] user_in_next;
  wire [CDM_BUS_W-1:0] wr_next;
  generate
    for (gi = 0; gi < CDM_BUS_W; gi++) begin : g_pin
      // drive only on a selected read, or per user_oe in user mode
      assign oe_next[gi] = is_user ? user_oe[gi] : (par_rd & par_lane[gi]);
      assign out_next[gi] = is_user ? user_out[gi] :
        (cfg_read_data[gi] & par_lane[gi]);
      // nothing reaches user logic before release
      assign user_in_next[gi] = is_user & data_sync[gi];
      // capture only on owned lanes of a write
      assign wr_next[gi] = par_wr & par_lane[gi] & data_sync[gi];
    end
  endgenerate

  // read data toward the pins
  // value is harmless while oe stays low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_pin_out <= CDM_DATA_RST;
    end else begin
      data_pin_out <= out_next;
    end
  end

  // pin drive enables
  // reset leaves every pin undriven
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_pin_oe <= CDM_OE_RST;
    end else begin
      data_pin_oe <= oe_next;
    end
  end

  // captured write data
  // zero outside a write so stale words never linger
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_write_data <= CDM_DATA_RST;
    end else begin
      cfg_write_data <= wr_next;
    end
  end

  // write strobe
  // high on every cycle of a selected write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_write_valid <= 1'b0;
    end else begin
      cfg_write_valid <= par_wr;
    end
  end

  // flash data lanes
  // unused lanes read as zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spi_data_in <= CDM_SPI_RST;
    end else begin
      spi_data_in <= spi_in_next;
    end
  end

  // single-line flash data
  // low in every other mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spi_x1_data_in <= 1'b0;
    end else begin
      spi_x1_data_in <= x1_in_next;
    end
  end

  // slave serial data
  // low in every other mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_data_in <= 1'b0;
    end else begin
      serial_data_in <= ser_in_next;
    end
  end

  // select level
  // follows the pin three edges late
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      par_selected <= 1'b0;
    end else begin
      par_selected <= par_sel;
    end
  end

  // read level
  // matches the edge on which oe rises
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      par_read <= 1'b0;
    end else begin
      par_read <= par_rd;
    end
  end

  // pin levels toward user logic
  // zero until the pins are released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      user_in <= CDM_DATA_RST;
    end else begin
      user_in <= user_in_next;
    end
  end

  // user ownership flag
  // one edge after the mode changes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      user_pins_owned <= 1'b0;
    end else begin
      user_pins_owned <= is_user;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/cdm_pin_mux_chk.sv ====
// port assertions for the config pin mux
`timescale 1ns/1ps
`default_nettype none
module cdm_pin_mux_chk import cdm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire cdm_mode_e cfg_mode,
  input wire cdm_width_e par_width,
  input wire logic [31:0] data_pin_oe,
  input wire logic [7:0] spi_data_in,
  input wire logic spi_x1_data_in,
  input wire logic serial_data_in,
  input wire logic par_read,
  input wire logic user_pins_owned
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_oe; |data_pin_oe |-> par_read||user_pins_owned; endproperty
  a_oe: assert property (p_oe) else $error("stray drive");
  property p_usr; cfg_mode==CDM_MODE_USER |=> user_pins_owned; endproperty
  a_usr: assert property (p_usr) else $error("not user");
  property p_hi; cfg_mode!=CDM_MODE_USER && par_width!=CDM_WIDTH_X32
    |=> data_pin_oe[31:16]==0; endproperty
  a_hi: assert property (p_hi) else $error("upper lanes");
  property p_mid; cfg_mode!=CDM_MODE_USER && par_width==CDM_WIDTH_X8
    |=> data_pin_oe[15:8]==0; endproperty
  a_mid: assert property (p_mid) else $error("mid lanes");
  property p_x1; cfg_mode!=CDM_MODE_SPI_X1 |=> !spi_x1_data_in; endproperty
  a_x1: assert property (p_x1) else $error("x1 input");
  property p_ss; cfg_mode!=CDM_MODE_SLAVE_SERIAL |=> !serial_data_in;
  endproperty
  a_ss: assert property (p_ss) else $error("serial input");
  property p_jt; cfg_mode==CDM_MODE_JTAG |=> spi_data_in==0; endproperty
  a_jt: assert property (p_jt) else $error("jtag input");
  property p_x2; cfg_mode==CDM_MODE_SPI_X2 |=> spi_data_in[7:2]==0;
  endproperty
  a_x2: assert property (p_x2) else $error("x2 lanes");
endmodule
bind cdm_pin_mux cdm_pin_mux_chk cdm_pin_mux_chk_inst (.*);
`default_nettype wire

// ==== testbench/cdm_ext_model.sv ====
// far side pin levels: controller or flash, else weak pull-up
`timescale 1ns/1ps
`default_nettype none
module cdm_ext_model (
  input wire logic chip_select_n_pin,
  input wire logic rw_select,
  input wire logic fen,
  input wire logic [31:0] wd,
  input wire logic [31:0] data_pin_out,
  input wire logic [31:0] data_pin_oe,
  output logic [31:0] data_pin_in
);
  // drives only on writes or flash data
  wire logic drv = fen || !chip_select_n_pin && !rw_select;
  assign data_pin_in = data_pin_oe & data_pin_out |
    ~data_pin_oe & (drv ? wd : '1);
endmodule
`default_nettype wire

// ==== testbench/cdm_pin_mux_tb_top.sv ====
// bench for the config pin mux
`timescale 1ns/1ps
`default_nettype none
module cdm_pin_mux_tb_top
  import cdm_pkg::*;
;
  logic clock = 0, resetn = 0, chip_select_n_pin = 1, rw_select = 1, fen = 0;
  cdm_mode_e cfg_mode = CDM_MODE_INIT;
  cdm_width_e par_width = CDM_WIDTH_X8;
  logic [31:0] cfg_read_data = '0, user_out = '0, user_oe = '0, wd = '0;
  wire logic [31:0] data_pin_in, data_pin_out, data_pin_oe, cfg_write_data;
  wire logic [31:0] user_in;
  wire logic [7:0] spi_data_in;
  wire logic cfg_write_valid, spi_x1_data_in, serial_data_in;
  wire logic par_selected, par_read, user_pins_owned;
  int errors = 0, check_count = 0, cyc = 0;
  always #50 clock = ~clock;
  cdm_pin_mux cdm_pin_mux_inst (.*);
  cdm_ext_model cdm_ext_model_inst (.chip_select_n_pin, .rw_select,
    .fen, .wd, .data_pin_out, .data_pin_oe, .data_pin_in);
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded waits; the run needs well under 200 cycles
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      cyc++;
      if (cyc > 400) begin
        errors++;
        finish_test;
      end
    end
    #10;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_spi;
    logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h06, 8'hA6};
    fen = 1;
    wd = 32'h0000_00A6;
    for (int i = 0; i < 4; i++) begin
      cfg_mode = cdm_mode_e'(2 + i);
      tick(4);
      if (i > 0) chk(spi_data_in, exp[i]);
      chk(spi_x1_data_in, i == 0);
    end
    cfg_mode = CDM_MODE_SLAVE_SERIAL;
    tick(4);
    chk(serial_data_in, 1);
    cfg_mode = CDM_MODE_JTAG;
    tick(4);
    fen = 0;
    $display("spi done");
  endtask
  task automatic t_par;
    cfg_mode = CDM_MODE_SLAVE_PARALLEL;
    par_width = CDM_WIDTH_X16;
    rw_select = 0;
    wd = 32'hA5A5_1234;
    tick(1);
    chip_select_n_pin = 0;
    tick(4);
    chk(cfg_write_data, 32'h0000_1234);
    chk(cfg_write_valid, 1);
    chk(data_pin_oe, 0);
    chip_select_n_pin = 1;
    par_width = CDM_WIDTH_X8;
    cfg_read_data = 32'hDEAD_BEEF;
    tick(1);
    rw_select = 1;
    tick(1);
    chip_select_n_pin = 0;
    tick(4);
    chk(data_pin_in, 32'hFFFF_FFEF);
    chk(par_read, 1);
    chk(par_selected, 1);
    chk(data_pin_out, 32'h0000_00EF);
    par_width = CDM_WIDTH_X32;
    tick(2);
    chk(data_pin_in, 32'hDEAD_BEEF);
    chip_select_n_pin = 1;
    tick(4);
    chk(data_pin_oe, 0);
    $display("parallel done");
  endtask
  task automatic t_user;
    cfg_mode = CDM_MODE_USER;
    user_out = 32'h1234_5678;
    user_oe = 32'h0000_FFFF;
    tick(4);
    chk(user_in, 32'hFFFF_5678);
    chk(user_pins_owned, 1);
    cfg_mode = CDM_MODE_INIT;
    tick(2);
    chk(data_pin_oe, 0);
    $display("user done");
  endtask
  initial begin
    tick(10);
    resetn = 1;
    tick(1);
    chk(data_pin_oe, 0);
    t_spi;
    t_par;
    t_user;
    finish_test;
  end
endmodule
`default_nettype wire
